/* rtl/css_pkg.sv */
package css_pkg;

	// ==========================================
	// Configuration and selection layout
	localparam int unsigned NUM_CONFIGS = 3;
	localparam int unsigned IDX_WIDTH   = 2;
	localparam logic [1:0]  IDX_RESET   = 2'h0;
	localparam logic [1:0]  IDX_CFG0    = 2'h0;
	localparam logic [1:0]  IDX_CFG1    = 2'h1;
	localparam logic [1:0]  IDX_CFG2    = 2'h2;

	// ==========================================
	// Parameter group swap mask bit positions
	localparam int unsigned GRP_SETTINGS  = 0;
	localparam int unsigned GRP_MOTOR_CTL = 1;
	localparam int unsigned GRP_IO        = 2;
	localparam int unsigned GRP_COMMAND   = 3;
	localparam int unsigned GRP_APPL      = 4;
	localparam int unsigned GRP_FAULT     = 5;
	localparam int unsigned GRP_USER_MENU = 6;
	localparam int unsigned GRP_NAME      = 7;
	localparam int unsigned GRP_MOTOR_DAT = 8;
	localparam int unsigned GRP_WIDTH     = 9;
	localparam logic [8:0]  GRP_NONE      = 9'h000;
	// Motor data is swapped only per motor
	localparam logic [8:0]  GRP_MULTIMOTOR = 9'h1ff;
	localparam logic [8:0]  GRP_MULTICONF  = 9'h0ff;

	// ==========================================
	// Thermal model
	localparam int unsigned THERM_WIDTH = 16;
	localparam logic [15:0] THERM_RESET = 16'h0000;
	localparam int unsigned COOL_DIV    = 1024;

	// ==========================================
	// Control states
	typedef enum logic [2:0] {
		ST_STOPPED = 3'h1,
		ST_RUNNING = 3'h2,
		ST_FAULT   = 3'h4
	} css_state_type;

endpackage

/* rtl/css_decode.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Selection input decoder, registered
module css_decode
(
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire logic       select_input_low_bit,
	input  wire logic       select_input_high_bit,
	input  wire logic       three_set_enable,
	output logic      [1:0] requested
);

	logic [1:0] next_requested;

	// High input dominates; it counts only with three sets
	always_comb
	begin
		if (select_input_high_bit && three_set_enable)
			next_requested = css_pkg::IDX_CFG2; // RULE_05
		else if (select_input_low_bit)
			next_requested = css_pkg::IDX_CFG1; // RULE_05
		else
			next_requested = css_pkg::IDX_CFG0; // RULE_05
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			requested <= css_pkg::IDX_RESET;
		else
			requested <= next_requested; // RULE_16
	end

endmodule

`default_nettype wire

/* rtl/css_switcher.sv */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE_01 - Three stored configurations, one made active
// RULE_02 - Per-motor or per-configuration mode, never both
// RULE_03 - Change only while stopped and locked
// RULE_04 - Running request waits for next stop
// RULE_05 - Decode: 00->0, 10->1, x1->2
// RULE_06 - Hardware mismatch gives locked fault
// RULE_07 - Per-motor swaps all groups except switching
// RULE_08 - Per-configuration keeps motor data shared
// RULE_09 - Nothing outside listed groups is swapped
// RULE_10 - Auto-tune on first motor activation
// RULE_11 - Separate thermal state, cooling while stopped
// RULE_12 - Third set only when enabled and chosen
// RULE_13 - Interdependent values limited at switching
// RULE_14 - Programmer keeps minimum below maximum speeds
// RULE_15 - Three sets need low input assigned
// RULE_16 - Registered selection loads on first stop
// RULE_17 - Active index held through running
module css_switcher
#(
	parameter int unsigned SPEED_WIDTH = 16,
	parameter int unsigned COOL_DIV    = css_pkg::COOL_DIV
)
(
	input  wire logic                   clock,
	input  wire logic                   srst,
	input  wire logic                   select_input_low_bit,
	input  wire logic                   select_input_high_bit,
	input  wire logic                   three_set_selector,
	input  wire logic                   params_chosen,
	input  wire logic                   multimotor_mode,
	input  wire logic                   tune_on_first_run,
	input  wire logic                   drive_stopped,
	input  wire logic                   power_locked,
	input  wire logic [2:0]             hw_match,
	input  wire logic                   motor_heating,
	input  wire logic [SPEED_WIDTH-1:0] minimum_speed_limit,
	input  wire logic [SPEED_WIDTH-1:0] maximum_speed_limit,
	output logic      [1:0]             active_index,
	output logic      [8:0]             swap_groups,
	output logic                        third_parameter_set,
	output logic                        bad_config_fault,
	output logic                        switch_pending,
	output logic                        tune_request,
	output logic      [SPEED_WIDTH-1:0] min_speed_applied,
	output logic      [SPEED_WIDTH-1:0] max_speed_applied,
	output logic      [47:0]            thermal_states
);

	// ==========================================
	// Selection decode
	logic       three_ok;
	logic [1:0] requested;
	logic       stop_ok;

	assign three_ok = three_set_selector && params_chosen; // RULE_12
	assign stop_ok  = drive_stopped && power_locked;        // RULE_03

	css_decode u_decode
	(
		.clock                 (clock),
		.srst                  (srst),
		.select_input_low_bit  (select_input_low_bit),
		.select_input_high_bit (select_input_high_bit),
		.three_set_enable      (three_ok),
		.requested             (requested)
	);

	// ==========================================
	// Switching state machine
	css_pkg::css_state_type state;
	css_pkg::css_state_type next_state;
	logic [1:0]             next_active_index;
	logic                   next_fault;
	logic                   next_pending;
	logic [8:0]             next_swap_groups;
	logic                   next_third;
	logic [2:0]             next_tuned;
	logic [2:0]             tuned;
	logic                   next_tune_request;
	logic [SPEED_WIDTH-1:0] next_min_applied;
	logic [SPEED_WIDTH-1:0] next_max_applied;

	// Index moves only on a stop; fault is left by a good stop selection
	always_comb
	begin
		next_state        = state;
		next_active_index = active_index;
		next_fault        = bad_config_fault;
		next_tuned        = tuned;
		next_tune_request = 1'b0;
		next_pending      = (requested != active_index); // RULE_04
		unique case (state)
			css_pkg::ST_STOPPED:
			begin
				if (stop_ok)
				begin
					next_active_index = requested; // RULE_01 RULE_16
					next_pending      = 1'b0;
					if (!hw_match[requested])
					begin
						next_state = css_pkg::ST_FAULT; // RULE_06
						next_fault = 1'b1;
					end
					else if (multimotor_mode && tune_on_first_run
						&& !tuned[requested])
					begin
						next_tune_request        = 1'b1; // RULE_10
						next_tuned[requested]    = 1'b1;
					end
				end
				if (!drive_stopped && hw_match[active_index])
					next_state = css_pkg::ST_RUNNING;
			end
			css_pkg::ST_RUNNING:
			begin
				// Inputs ignored here; the index is frozen
				if (drive_stopped)
					next_state = css_pkg::ST_STOPPED; // RULE_17
			end
			css_pkg::ST_FAULT:
			begin
				// Locked: recover only by a valid selection at a stop
				if (stop_ok && hw_match[requested])
				begin
					next_state        = css_pkg::ST_STOPPED;
					next_fault        = 1'b0;
					next_active_index = requested; // RULE_06
				end
			end
			default:
				next_state = css_pkg::ST_FAULT;
		endcase
		// One mode at a time picks the swap set
		if (multimotor_mode)
			next_swap_groups = css_pkg::GRP_MULTIMOTOR; // RULE_02 RULE_07
		else
			next_swap_groups = css_pkg::GRP_MULTICONF; // RULE_08 RULE_09
		next_third = three_ok; // RULE_12
		// Clamp so minimum never exceeds maximum in the new set
		next_max_applied = maximum_speed_limit;
		if (minimum_speed_limit > maximum_speed_limit)
			next_min_applied = maximum_speed_limit; // RULE_13 RULE_14
		else
			next_min_applied = minimum_speed_limit;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state               <= css_pkg::ST_STOPPED;
			active_index        <= css_pkg::IDX_RESET;
			bad_config_fault    <= 1'b0;
			switch_pending      <= 1'b0;
			tuned               <= 3'h0;
			tune_request        <= 1'b0;
			swap_groups         <= css_pkg::GRP_NONE;
			third_parameter_set <= 1'b0;
			min_speed_applied   <= '0;
			max_speed_applied   <= '0;
		end
		else
		begin
			state               <= next_state;
			active_index        <= next_active_index;
			bad_config_fault    <= next_fault;
			switch_pending      <= next_pending;
			tuned               <= next_tuned;
			tune_request        <= next_tune_request;
			swap_groups         <= next_swap_groups;
			third_parameter_set <= next_third;
			min_speed_applied   <= next_min_applied;
			max_speed_applied   <= next_max_applied;
		end
	end

	// ==========================================
	// Per-motor thermal states
	logic [9:0] cool_cnt;
	logic [9:0] next_cool_cnt;
	logic       cool_tick;

	// Shared divider keeps cooling slow relative to heating
	always_comb
	begin
		cool_tick     = (cool_cnt == 10'(COOL_DIV - 1));
		next_cool_cnt = cool_tick ? 10'h000 : cool_cnt + 10'h001;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			cool_cnt <= 10'h000;
		else
			cool_cnt <= next_cool_cnt;
	end

	genvar m;
	generate
		for (m = 0; m < 3; m++)
		begin : g_therm
			logic [15:0] therm;
			logic [15:0] next_therm;
			logic        is_on;
			// Idle motors keep cooling; only power loss forgets
			always_comb
			begin
				is_on      = (active_index == 2'(m)) && !drive_stopped;
				next_therm = therm;
				if (is_on && motor_heating && therm != 16'hffff)
					next_therm = therm + 16'h0001; // RULE_11
				else if (!(is_on && motor_heating) && cool_tick
					&& therm != 16'h0000)
					next_therm = therm - 16'h0001; // RULE_11
			end
			always_ff @(posedge clock)
			begin
				if (srst)
					therm <= css_pkg::THERM_RESET;
				else
					therm <= next_therm;
			end
		end
	endgenerate

	// One driver for the packed view; each slice is a motor's flop
	assign thermal_states = {g_therm[2].therm, g_therm[1].therm,
		g_therm[0].therm}; // RULE_11

	// ==========================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	AST_HOLD_RUNNING: assert property ( // RULE_17
		(state == css_pkg::ST_RUNNING) && !drive_stopped
		|=> $stable(active_index))
		else $error("active index moved while running");
	AST_CHANGE_ONLY_STOPPED: assert property ( // RULE_03
		$changed(active_index) |-> $past(stop_ok))
		else $error("index changed without stop");
	AST_LOAD_ON_STOP: assert property ( // RULE_16
		(state == css_pkg::ST_STOPPED) && stop_ok
		|=> active_index == $past(requested))
		else $error("selection not loaded at stop");
	AST_PENDING_WAIT: assert property ( // RULE_04
		(state == css_pkg::ST_RUNNING) && (requested != active_index)
		&& !drive_stopped |=> switch_pending)
		else $error("pending not shown");
	AST_FAULT_MISMATCH: assert property ( // RULE_06
		(state == css_pkg::ST_STOPPED) && stop_ok && !hw_match[requested]
		|=> bad_config_fault && state == css_pkg::ST_FAULT)
		else $error("mismatch not faulted");
	AST_SWAP_MODE: assert property ( // RULE_08
		!multimotor_mode |=> swap_groups[css_pkg::GRP_MOTOR_DAT] == 1'b0)
		else $error("motor data swapped in config mode");
	AST_THIRD_SET: assert property ( // RULE_12
		third_parameter_set |-> $past(three_set_selector && params_chosen))
		else $error("third set without enable");
	AST_IDX_RANGE: assert property ( // RULE_01
		active_index != 2'h3)
		else $error("illegal index");
	AST_CLAMP: assert property ( // RULE_13
		##1 min_speed_applied <= max_speed_applied)
		else $error("minimum above maximum");
	AST_TUNE_ONCE: assert property ( // RULE_10
		tune_request |=> !tune_request)
		else $error("tune request repeated");

	// Fault, pending, tuning and thermal guards
	AST_FAULT_HELD: assert property ( // RULE_06
		bad_config_fault && !(stop_ok && hw_match[requested])
		|=> bad_config_fault)
		else $error("fault left without valid stop");
	AST_NO_RUN_MISMATCH: assert property ( // RULE_06
		(state != css_pkg::ST_RUNNING) && !hw_match[active_index]
		|=> state != css_pkg::ST_RUNNING)
		else $error("running on mismatched configuration");
	AST_PENDING_CLEAR: assert property ( // RULE_16
		(state == css_pkg::ST_STOPPED) && stop_ok |=> !switch_pending)
		else $error("pending left after stop load");
	AST_TUNE_FIRST: assert property ( // RULE_10
		tune_request |->
		$past(multimotor_mode && tune_on_first_run && !tuned[requested]))
		else $error("tune request for tuned motor");
	AST_IDLE_NO_HEAT: assert property ( // RULE_11
		!((active_index == 2'h0) && !drive_stopped)
		|=> thermal_states[15:0] <= $past(thermal_states[15:0]))
		else $error("idle motor heated");

	COV_SWITCH: cover property ($changed(active_index));
	COV_DEFER: cover property (switch_pending ##[1:20] !switch_pending);
	COV_FAULT: cover property (bad_config_fault);
	COV_TUNE: cover property (tune_request);
	COV_RUN_STOP: cover property ((state == css_pkg::ST_RUNNING)
		##1 (state == css_pkg::ST_STOPPED));

endmodule

`default_nettype wire

/* tb/css_switch_panel.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Switch panel feeding the two selection inputs
module css_switch_panel
(
	input  wire logic [1:0] want,
	output logic            select_input_low_bit,
	output logic            select_input_high_bit
);
	// Low input kept assigned for three sets; code 3 drives high alone
	always_comb
	begin
		select_input_low_bit  = (want == 2'h1) || (want == 2'h2);
		select_input_high_bit = want[1];
	end
endmodule
`default_nettype wire

/* tb/config_set_switcher_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Bench for the configuration set switcher
module config_set_switcher_tb;
	logic        clock = 1'b0;
	logic        srst;
	logic [1:0]  want;
	logic        lo;
	logic        hi;
	logic        tss;
	logic        pch;
	logic        mm;
	logic        tune;
	logic        stp;
	logic        lck;
	logic [2:0]  hw;
	logic        heat;
	logic [15:0] mins;
	logic [15:0] maxs;
	logic [1:0]  ai;
	logic [8:0]  sg;
	logic        tps;
	logic        fault;
	logic        pend;
	logic        treq;
	logic [15:0] mina;
	logic [15:0] maxa;
	logic [47:0] therm;
	int          errors = 0;
	int          n_checks = 0;
	int          cycles = 0;

	css_switch_panel panel (.want(want), .select_input_low_bit(lo),
		.select_input_high_bit(hi));

	// Short cooling divider keeps the thermal test brief
	css_switcher #(.SPEED_WIDTH(16), .COOL_DIV(4)) DUT (
		.clock(clock), .srst(srst), .select_input_low_bit(lo),
		.select_input_high_bit(hi), .three_set_selector(tss),
		.params_chosen(pch), .multimotor_mode(mm),
		.tune_on_first_run(tune), .drive_stopped(stp),
		.power_locked(lck), .hw_match(hw), .motor_heating(heat),
		.minimum_speed_limit(mins), .maximum_speed_limit(maxs),
		.active_index(ai), .swap_groups(sg), .third_parameter_set(tps),
		.bad_config_fault(fault), .switch_pending(pend),
		.tune_request(treq), .min_speed_applied(mina),
		.max_speed_applied(maxa), .thermal_states(therm));

	always #4 clock = ~clock;

	// Hang guard, well above the expected run
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// Inputs always change 1 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic tally_and_finish;
		if (errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Only one pulse on first use of a motor, none on return
	task automatic t_tune;
		int cnt;
		cnt = 0;
		want = 2'h1;
		repeat (6)
		begin
			tick(1);
			cnt += int'(treq);
		end
		check(cnt, 1);
		want = 2'h0;
		tick(4);
		want = 2'h1;
		cnt = 0;
		repeat (6)
		begin
			tick(1);
			cnt += int'(treq);
		end
		check(cnt, 0);
	endtask

	task automatic t_decode;
		logic [1:0] exp [4];
		exp = '{2'h0, 2'h1, 2'h2, 2'h2};
		for (int i = 0; i < 4; i++)
		begin
			want = 2'(i);
			tick(3);
			check(ai, exp[i]);
			check(pend, 1'b0);
			check(sg, 9'h1ff);
		end
		mm = 1'b0;
		tick(3);
		check(sg, 9'h0ff);
		mm = 1'b1;
		tick(3);
		check(sg, 9'h1ff);
	endtask

	// Request while running waits; an unlocked stop is not enough
	task automatic t_run;
		stp = 1'b0;
		tick(2);
		want = 2'h1;
		tick(4);
		check(ai, 2'h2);
		check(pend, 1'b1);
		stp = 1'b1;
		lck = 1'b0;
		tick(4);
		check(ai, 2'h2);
		lck = 1'b1;
		tick(3);
		check(ai, 2'h1);
	endtask

	task automatic t_fault;
		hw = 3'h3;
		want = 2'h2;
		tick(3);
		check(fault, 1'b1);
		stp = 1'b0;
		tick(3);
		check(fault, 1'b1);
		stp = 1'b1;
		want = 2'h0;
		tick(3);
		check(fault, 1'b0);
		check(ai, 2'h0);
		hw = 3'h7;
	endtask

	task automatic t_misc;
		mins = 16'h00c8;
		maxs = 16'h0032;
		tick(3);
		check(mina, 16'h0032);
		check(maxa, 16'h0032);
		tss = 1'b0;
		tick(3);
		check(tps, 1'b0);
		tss = 1'b1;
		pch = 1'b0;
		tick(3);
		check(tps, 1'b0);
		pch = 1'b1;
		tick(3);
		check(tps, 1'b1);
		mins = 16'h000a;
		maxs = 16'h0064;
	endtask

	// Motor 0 heats alone, then cools while stopped
	task automatic t_therm;
		logic [15:0] hot;
		stp = 1'b0;
		heat = 1'b1;
		tick(20);
		hot = therm[15:0];
		check(therm[47:16], 32'h0);
		check(hot != 16'h0, 1'b1);
		heat = 1'b0;
		stp = 1'b1;
		tick(40);
		check(therm[15:0] < hot, 1'b1);
	endtask

	initial
	begin
		srst = 1'b1;
		want = 2'h0;
		tss = 1'b1;
		pch = 1'b1;
		mm = 1'b1;
		tune = 1'b1;
		stp = 1'b1;
		lck = 1'b1;
		hw = 3'h7;
		heat = 1'b0;
		mins = 16'h000a;
		maxs = 16'h0064;
		tick(5);
		check(ai, 2'h0);
		check(sg, 9'h000);
		check(fault, 1'b0);
		srst = 1'b0;
		tick(1);
		t_tune();
		t_decode();
		t_run();
		t_fault();
		t_misc();
		t_therm();
		tally_and_finish();
	end
endmodule
`default_nettype wire
